// ===== rtl/abc_map.svh
// constants for the atomic byte bit-clear unit
// Summary of operation
// - standard form: 000001, 00111, bit15 zero
// - compact form: 001000, 25:24 zero, 1011
// - address is sign-extended offset plus base
// - one byte read at that address
// - clear indexed bit, keep other seven bits
// - write modified byte to same address
// - save and clear interrupt enable, then restore
// - memory lock during sequence is optional
// - translation, address and watch faults abort before write
// - store-type miss and address-error codes recorded
// - fixed classification for watch: store
`ifndef ABC_MAP_SVH
`define ABC_MAP_SVH
`define ABC_STD_MAJOR      6'h01
`define ABC_STD_SUB        5'h07
`define ABC_CMP_MAJOR      6'h08
`define ABC_CMP_SUB        4'hb
`define ABC_MAJOR_MSB      31
`define ABC_MAJOR_LSB      26
`define ABC_OFFSET_W       12
`define ABC_EXC_MOD        5'h01
`define ABC_EXC_TLBL       5'h02
`define ABC_EXC_STORE_MISS 5'h03
`define ABC_EXC_STORE_ADDR 5'h05
`define ABC_EXC_WATCH      5'h17
`define ABC_USE_LOCK       1'b1
`endif

// ===== rtl/abc_pkg.sv
// types shared by the atomic bit-clear unit
package abc_pkg;
  typedef enum logic [2:0] {
    ABC_IDLE,
    ABC_GPR,
    ABC_XLAT,
    ABC_MASK,
    ABC_READ,
    ABC_WRITE
  } abc_state_e;
  typedef logic [4:0] abc_reg_idx_t;
endpackage

// ===== rtl/abc_dec_if.sv
// decoded instruction fields passed from decoder to sequencer
`timescale 1ns/1ps
interface abc_dec_if;
  import abc_pkg::*;
  logic         hit;
  abc_reg_idx_t base_idx;
  logic [2:0]   bit_idx;
  logic [11:0]  offset;
  modport dec  (output hit, output base_idx, output bit_idx, output offset);
  modport core (input hit, input base_idx, input bit_idx, input offset);
endinterface

// ===== rtl/abc_decode.sv
// combinational decoder for both encodings of the bit-clear instruction
`timescale 1ns/1ps
`include "abc_map.svh"
module abc_decode import abc_pkg::*; (
  // instruction
  input  wire logic [31:0] instr,
  input  wire logic        compact,
  // decoded fields
  abc_dec_if.dec           fld
);
  logic std_hit;
  logic cmp_hit;

  assign std_hit = (instr[31:26] == `ABC_STD_MAJOR) && (instr[20:16] == `ABC_STD_SUB)
                   && !instr[15];
  assign cmp_hit = (instr[31:26] == `ABC_CMP_MAJOR) && (instr[25:24] == 2'h0)
                   && (instr[15:12] == `ABC_CMP_SUB);

  always_comb begin
    fld.hit      = compact ? cmp_hit : std_hit;
    fld.base_idx = compact ? instr[20:16] : instr[25:21];
    fld.bit_idx  = compact ? instr[23:21] : instr[14:12];
    fld.offset   = instr[11:0];
  end
endmodule

// ===== rtl/abc_top.sv
// read-modify-write sequencer for the atomic byte bit-clear instruction
`timescale 1ns/1ps
`include "abc_map.svh"
module abc_top import abc_pkg::*; #(
  parameter int DATA_W = 32
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // pipeline side
  input  wire logic              instr_valid,
  input  wire logic [31:0]       instr_word,
  input  wire logic              instr_compact,
  output logic                   instr_accept,
  output logic                   busy,
  output logic                   done,
  // general register read
  output abc_reg_idx_t           gpr_rd_addr,
  input  wire logic [DATA_W-1:0] gpr_rd_data,
  // endianness
  input  wire logic              big_endian,
  input  wire logic              reverse_endian,
  // interrupt enable
  input  wire logic              ie_current,
  output logic                   ie_wr_en,
  output logic                   ie_wr_data,
  // address translation
  output logic                   xlat_req,
  output logic [DATA_W-1:0]      xlat_vaddr,
  output logic                   xlat_is_store,
  input  wire logic              xlat_ack,
  input  wire logic [DATA_W-1:0] xlat_paddr,
  input  wire logic              xlat_refill,
  input  wire logic              xlat_invalid,
  input  wire logic              xlat_modified,
  input  wire logic              xlat_addr_err,
  input  wire logic              xlat_watch,
  // data memory
  output logic                   mem_req,
  output logic                   mem_we,
  output logic                   mem_lock,
  output logic [DATA_W-1:0]      mem_addr,
  output logic [3:0]             mem_be,
  output logic [DATA_W-1:0]      mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [DATA_W-1:0] mem_rdata,
  // exception report
  output logic                   exc_valid,
  output logic [4:0]             exc_code,
  output logic                   exc_is_store,
  output logic [DATA_W-1:0]      exc_badvaddr
);
  // the lane and byte-enable logic assume four byte lanes
  if (DATA_W != 32) begin : g_width_chk
    $error("abc_top serves only a 32-bit data path");
  end

  abc_dec_if  dec_bus ();
  abc_state_e state_ff;
  logic [2:0] bit_ff;
  logic [11:0] off_ff;
  logic       saved_ie_ff;
  logic [1:0] lane_ff;
  logic [1:0] lane;
  logic [7:0] old_byte;
  logic [7:0] new_byte;
  logic       fault;
  logic [4:0] fault_code;

  abc_decode u_dec (
    .instr   (instr_word),
    .compact (instr_compact),
    .fld     (dec_bus)
  );

  // reverse_endian is not used; the lane is the two low address bits flipped by big_endian alone,
  // so reverse_endian leaves this byte access unchanged
  // lane fixed at translation time so read and write hit the same byte
  assign lane     = xlat_vaddr[1:0] ^ {2{big_endian}};
  assign old_byte = mem_rdata[8*lane_ff +: 8];
  // one clear term per bit of the fetched byte
  for (genvar i = 0; i < 8; i++) begin : g_clr
    assign new_byte[i] = old_byte[i] & (bit_ff != 3'(i));
  end
  assign fault    = xlat_refill | xlat_invalid | xlat_modified | xlat_addr_err | xlat_watch;

  // priority: address error first, then miss, then protection, then watch
  always_comb begin
    if (xlat_addr_err) begin
      fault_code = `ABC_EXC_STORE_ADDR;
    end else if (xlat_refill || xlat_invalid) begin
      fault_code = `ABC_EXC_STORE_MISS;
    end else if (xlat_modified) begin
      fault_code = `ABC_EXC_MOD;
    end else begin
      fault_code = `ABC_EXC_WATCH;
    end
  end

  // sequencer and datapath
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff      <= ABC_IDLE;
      bit_ff        <= 3'h0;
      off_ff        <= 12'h000;
      saved_ie_ff   <= 1'b0;
      lane_ff       <= 2'h0;
      gpr_rd_addr   <= 5'h00;
      xlat_req      <= 1'b0;
      xlat_vaddr    <= 32'h0000_0000;
      xlat_is_store <= 1'b1;
      mem_req       <= 1'b0;
      mem_we        <= 1'b0;
      mem_lock      <= 1'b0;
      mem_addr      <= 32'h0000_0000;
      mem_be        <= 4'h0;
      mem_wdata     <= 32'h0000_0000;
      exc_code      <= 5'h00;
      exc_badvaddr  <= 32'h0000_0000;
      busy          <= 1'b0;
    end else if (clk_en) begin
      xlat_is_store <= 1'b1;
      case (state_ff)
        ABC_IDLE: begin
          if (instr_valid && dec_bus.hit) begin
            bit_ff      <= dec_bus.bit_idx;
            off_ff      <= dec_bus.offset;
            gpr_rd_addr <= dec_bus.base_idx;
            busy        <= 1'b1;
            state_ff    <= ABC_GPR;
          end
        end
        ABC_GPR: begin
          xlat_vaddr <= gpr_rd_data + {{(DATA_W-`ABC_OFFSET_W){off_ff[11]}}, off_ff};
          xlat_req   <= 1'b1;
          state_ff   <= ABC_XLAT;
        end
        ABC_XLAT: begin
          if (xlat_ack) begin
            xlat_req <= 1'b0;
            if (fault) begin
              exc_code     <= fault_code;
              exc_badvaddr <= xlat_vaddr;
              busy         <= 1'b0;
              state_ff     <= ABC_IDLE;
            end else begin
              lane_ff     <= lane;
              mem_addr    <= {xlat_paddr[31:2], 2'h0};
              // enable saved here; the clear pulse leaves on this same edge
              saved_ie_ff <= ie_current;
              state_ff    <= ABC_MASK;
            end
          end
        end
        ABC_MASK: begin
          // enable is already cleared when the read leaves
          mem_req  <= 1'b1;
          mem_we   <= 1'b0;
          mem_lock <= `ABC_USE_LOCK;
          mem_be   <= 4'h1 << lane_ff;
          state_ff <= ABC_READ;
        end
        ABC_READ: begin
          if (mem_ack) begin
            // read data is valid only in its ack cycle, so the byte is taken now
            mem_we    <= 1'b1;
            mem_wdata <= {24'h00_0000, new_byte} << (8*lane_ff);
            state_ff  <= ABC_WRITE;
          end
        end
        ABC_WRITE: begin
          if (mem_ack) begin
            mem_req  <= 1'b0;
            mem_we   <= 1'b0;
            mem_lock <= 1'b0;
            busy     <= 1'b0;
            state_ff <= ABC_IDLE;
          end
        end
        default: begin
          state_ff <= ABC_IDLE;
        end
      endcase
    end
  end

  // one-cycle strobes and the fixed store flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_accept <= 1'b0;
      done         <= 1'b0;
      exc_valid    <= 1'b0;
      exc_is_store <= 1'b1;
    end else if (clk_en) begin
      instr_accept <= (state_ff == ABC_IDLE) && instr_valid && dec_bus.hit;
      exc_valid    <= (state_ff == ABC_XLAT) && xlat_ack && fault;
      exc_is_store <= 1'b1;
      done         <= ((state_ff == ABC_WRITE) && mem_ack) || ((state_ff == ABC_XLAT) && xlat_ack && fault);
    end
  end

  // interrupt enable handling: clear before the read, restore after the write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ie_wr_en   <= 1'b0;
      ie_wr_data <= 1'b0;
    end else if (clk_en) begin
      if (state_ff == ABC_XLAT && xlat_ack && !fault) begin
        ie_wr_en   <= 1'b1;
        ie_wr_data <= 1'b0;
      end else if (state_ff == ABC_WRITE && mem_ack) begin
        ie_wr_en   <= 1'b1;
        ie_wr_data <= saved_ie_ff;
      end else begin
        ie_wr_en   <= 1'b0;
        ie_wr_data <= 1'b0;
      end
    end
  end
endmodule

// ===== bench/abc_checker.sv
// port assertions for the bit-clear sequencer
`timescale 1ns/1ps
module abc_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // pipeline and interrupt enable
  input wire logic        instr_accept,
  input wire logic        done,
  input wire logic        ie_wr_en,
  input wire logic        ie_wr_data,
  // translation
  input wire logic        xlat_req,
  input wire logic        xlat_is_store,
  input wire logic        xlat_ack,
  input wire logic        xlat_refill,
  input wire logic        xlat_addr_err,
  // memory and exceptions
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_lock,
  input wire logic [3:0]  mem_be,
  input wire logic [31:0] mem_addr,
  input wire logic        exc_valid,
  input wire logic [4:0]  exc_code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_done_bound: assert property (instr_accept |-> ##[3:60] done)
    else $error("sequence did not finish");
  a_ie_clear: assert property ($rose(mem_req) |-> $past(ie_wr_en) && !$past(ie_wr_data))
    else $error("enable not cleared before read");
  a_ie_restore: assert property (done && !exc_valid |-> ie_wr_en)
    else $error("enable not restored at end");
  a_store_xlat: assert property (xlat_req |-> xlat_is_store)
    else $error("translation not marked as store");
  a_addr_code: assert property (xlat_req && xlat_ack && xlat_addr_err |=> exc_valid && exc_code == 5'h05)
    else $error("wrong address error code");
  a_miss_code: assert property (xlat_req && xlat_ack && xlat_refill && !xlat_addr_err |=>
    exc_valid && exc_code == 5'h03)
    else $error("wrong translation miss code");
  a_fault_nomem: assert property (exc_valid |-> !mem_req && !ie_wr_en)
    else $error("memory touched on fault");
  a_lane_lock: assert property (mem_req |-> $onehot(mem_be) && mem_lock)
    else $error("bad byte lane or lock");
  a_same_addr: assert property (mem_req && mem_we |-> $stable(mem_addr) && $stable(mem_be))
    else $error("write address differs from read");
  c_accept: cover property (instr_accept);
  c_write: cover property (mem_req && mem_we && mem_lock);
  c_fault: cover property (exc_valid);
endmodule
bind abc_top abc_checker i_abc_checker (.ref_clk, .reset_n, .instr_accept, .done, .ie_wr_en, .ie_wr_data,
  .xlat_req, .xlat_is_store, .xlat_ack, .xlat_refill, .xlat_addr_err, .mem_req, .mem_we, .mem_lock,
  .mem_be, .mem_addr, .exc_valid, .exc_code);

// ===== bench/abc_mem_model.sv
// translation and data memory model facing the sequencer
`timescale 1ns/1ps
module abc_mem_model (
  // clock, reset and test control
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        slow,
  input  wire logic [4:0]  fault,
  // translation
  input  wire logic        xlat_req,
  input  wire logic [31:0] xlat_vaddr,
  output logic             xlat_ack,
  output logic [31:0]      xlat_paddr,
  output logic [4:0]       xlat_flags,
  // memory
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [16];
  logic [2:0]  wait_ff;
  wire  logic  xw = xlat_req && !xlat_ack;
  wire  logic  mw = mem_req && !mem_ack;
  wire  logic  go = wait_ff >= (slow ? 3'h3 : 3'h0);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) mem[i] <= 32'hffffffff;
      {wait_ff, xlat_ack, mem_ack, xlat_flags} <= '0;
      {xlat_paddr, mem_rdata} <= '0;
    end else begin
      wait_ff    <= ((xw || mw) && !go) ? wait_ff + 3'h1 : 3'h0;
      xlat_ack   <= xw && go;
      mem_ack    <= mw && go;
      xlat_flags <= (xw && go) ? fault : 5'h00;
      // outside an answer the buses toggle so stale values never look valid
      xlat_paddr <= (xw && go) ? xlat_vaddr : ~xlat_paddr;
      mem_rdata  <= (mw && go && !mem_we) ? mem[mem_addr[5:2]] : ~mem_rdata;
      for (int i = 0; i < 4; i++)
        if (mw && go && mem_we && mem_be[i]) mem[mem_addr[5:2]][8*i+:8] <= mem_wdata[8*i+:8];
    end
  end
endmodule

// ===== bench/tb_top.sv
// testbench for the atomic byte bit-clear sequencer
`timescale 1ns/1ps
module tb_top;
  import abc_pkg::*;
  logic ref_clk = 0, reset_n = 0, clk_en = 1, instr_valid = 0, instr_compact = 0, big_endian = 0;
  logic reverse_endian = 0, ie_current = 1, slow = 0, xlat_ack, xlat_refill, xlat_invalid, xlat_modified;
  logic xlat_addr_err, xlat_watch, mem_ack, instr_accept, busy, done, ie_wr_en, ie_wr_data, xlat_req;
  logic xlat_is_store, mem_req, mem_we, mem_lock, exc_valid, exc_is_store, ok;
  logic [31:0] instr_word = 0, gpr_rd_data, xlat_vaddr, xlat_paddr, mem_addr, mem_wdata, mem_rdata, exc_badvaddr;
  logic [4:0] fault = 0, exc_code;
  logic [3:0] mem_be;
  abc_reg_idx_t gpr_rd_addr;
  int errors = 0, tests_run = 0;
  abc_top i_abc_top (.*);
  abc_mem_model i_abc_mem_model (.*, .xlat_flags({xlat_addr_err, xlat_refill, xlat_invalid, xlat_modified, xlat_watch}));
  // base register n holds 0x1000 + n*0x100
  assign gpr_rd_data = {19'h0, gpr_rd_addr, 8'h00} + 32'h1000;
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (ie_wr_en) ie_current <= ie_wr_data;
  task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // one instruction at a time, never in a delay slot
  task run(input logic [31:0] w, input logic c, input logic [4:0] f);
    @(posedge ref_clk) {instr_word, instr_compact, fault, instr_valid} <= {w, c, f, 1'b1};
    repeat (8) begin @(negedge ref_clk); if (instr_accept === 1'b1) break; end
    ok = instr_accept;
    @(posedge ref_clk) instr_valid <= 0;
    if (ok) repeat (40) begin @(negedge ref_clk); if (done === 1'b1) break; end
  endtask
  task t_std_bits;
    logic [31:0] e;
    e = 32'hffffffff;
    for (int b = 0; b < 8; b++) begin
      run({6'h01, 5'd2, 5'h07, 1'b0, 3'(b), 12'h005}, 0, 0);
      e[8+b] = 0;
      chk("done", 1, done);
      chk("busy", 0, busy);
      chk("mem", e, i_abc_mem_model.mem[1]);
      // the restore pulse stands with done; the enable itself follows one edge later
      @(negedge ref_clk);
      chk("ie", 1, ie_current);
    end
  endtask
  task t_cmp_neg;
    @(posedge ref_clk) {big_endian, slow} <= 2'b11;
    run({6'h08, 2'b00, 3'd5, 5'd3, 4'hb, 12'hffe}, 1, 0);
    chk("mem", 32'hffffdfff, i_abc_mem_model.mem[15]);
    chk("exc", 0, exc_valid);
    @(posedge ref_clk) {big_endian, slow} <= 2'b00;
  endtask
  task t_faults;
    logic [4:0] code [5];
    code = '{5'h17, 5'h01, 5'h03, 5'h03, 5'h05};
    for (int i = 0; i < 5; i++) begin
      run({6'h01, 5'd4, 5'h07, 1'b0, 3'd0, 12'h000}, 0, 5'(1 << i));
      chk("exc", 1, exc_valid);
      chk("code", code[i], exc_code);
      chk("badvaddr", 32'h0000_1400, exc_badvaddr);
      chk("is_store", 1, exc_is_store);
      chk("mem", 32'hffffffff, i_abc_mem_model.mem[0]);
      chk("ie", 1, ie_current);
    end
  endtask
  task t_other_forms;
    run({6'h01, 5'd2, 5'h07, 1'b1, 3'd0, 12'h005}, 0, 0);
    chk("accept", 0, ok);
    run({6'h08, 2'b00, 3'd0, 5'd3, 4'h3, 12'hffe}, 1, 0);
    chk("accept", 0, ok);
  endtask
  task results;
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1;
    t_std_bits;
    t_cmp_neg;
    t_faults;
    t_other_forms;
    results;
  end
  initial begin
    #(25 * 4000);
    errors++;
    results;
  end
endmodule
